// File: hw/flash_cmd_seq.sv
// flash command sequencer: section erase-verify and read-once commands
// assumes the array answers each read request with a one-cycle ack on the bus clock
//
// Contract
// - erase-verify takes code 03 and addr 17:16, addr 15:0, phrase count.
// - clearing the complete flag launches the blank check; flag sets when done.
// - a blank check failure sets both array status bits.
// - access error if command word index is not 010 at erase-verify launch.
// - access error if erase-verify is not available in the current mode.
// - access error if the 18-bit start address is invalid.
// - access error if the start address is not phrase aligned.
// - access error if the section crosses the program flash boundary.
// - status bit 1 sets on any read error or blank failure.
// - status bit 0 sets only on uncorrectable error or blank failure.
// - read-once reads a 64-byte, 8-phrase field in the information register.
// - read-once takes code 04, phrase index 0 to 7; returns words 010..101.
// - divider loaded bit reads 0 until a write after reset, then 1.
// - lock bit freezes divider value; only reset clears it.
// - divider value divides the bus clock down to the 1 MHz timebase.
// - a phrase is four aligned 16-bit words, eight bytes.
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_seq #(
    parameter logic [17:0] PFLASH_FIRST = flash_pkg::PFLASH_FIRST,
    parameter logic [17:0] PFLASH_LAST  = flash_pkg::PFLASH_LAST
) (
    input  wire logic                                 clk_i,
    input  wire logic                                 rst_n_i,
    input  wire logic [flash_pkg::REG_ADDR_W-1:0]     reg_addr_i,
    input  wire logic [flash_pkg::REG_DATA_W-1:0]     reg_wdata_i,
    input  wire logic                                 reg_wr_i,
    input  wire logic                                 reg_rd_i,
    output logic      [flash_pkg::REG_DATA_W-1:0]     reg_rdata_o,
    input  wire logic                                 mode_allows_verify_i,
    output logic                                      array_req_o,
    output logic                                      array_ifr_o,
    output logic      [17:0]                          array_addr_o,
    input  wire logic [15:0]                          array_rdata_i,
    input  wire logic                                 array_ack_i,
    input  wire logic                                 array_ecc_single_i,
    input  wire logic                                 array_ecc_double_i,
    output logic                                      timebase_tick_o
);
    if (PFLASH_LAST < PFLASH_FIRST || PFLASH_FIRST[2:0] != 3'h0) begin : g_bad_range
        $error("program flash range must be ordered and phrase aligned");
    end

    flash_clkdiv_if div_if ();

    flash_clkdiv u_clkdiv (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .bus     (div_if.div)
    );

    flash_pkg::seq_state_t state;
    logic [15:0]            cmd_word [flash_pkg::CMD_WORDS];
    logic [2:0]             command_word_index;
    logic                   command_complete_flag;
    logic                   access_error_flag;
    logic                   protection_violation_flag;
    logic [1:0]             array_op_status;
    logic [17:0]            words_left;

    logic                   status_wr;
    logic                   launch;
    logic [7:0]             cmd_code;
    logic                   is_verify;
    logic                   is_read_once;
    logic [17:0]            ev_start;
    logic [19:0]            ev_end;
    logic                   check_err;
    logic                   blank_fail;
    logic                   word_ack;
    logic [2:0]             result_index;

    assign status_wr    = reg_wr_i && reg_addr_i == flash_pkg::OFF_STATUS;
    assign launch       = status_wr && reg_wdata_i[flash_pkg::COMPLETE_BIT] && command_complete_flag;
    assign cmd_code     = cmd_word[0][15:8];
    assign is_verify    = cmd_code == flash_pkg::CMD_ERASE_VERIFY;
    assign is_read_once = cmd_code == flash_pkg::CMD_READ_ONCE;
    assign ev_start     = {cmd_word[0][1:0], cmd_word[1]};
    assign ev_end       = {2'b00, ev_start} + {1'b0, cmd_word[2], 3'b000};
    assign word_ack     = state == flash_pkg::S_READ && array_ack_i;
    assign blank_fail   = word_ack && is_verify && array_rdata_i != flash_pkg::ERASED_WORD;
    assign result_index = flash_pkg::RO_FIRST_RESULT + {1'b0, array_addr_o[2:1]};

    // launch-time checks; any hit ends the command without touching the array
    always_comb begin
        check_err = 1'b0;
        if (!div_if.value[flash_pkg::DIV_LOADED_BIT]) begin
            check_err = 1'b1;
        end
        if (is_verify) begin
            if (command_word_index != flash_pkg::EV_LAUNCH_INDEX) begin
                check_err = 1'b1;
            end
            if (!mode_allows_verify_i) begin
                check_err = 1'b1;
            end
            if (ev_start < PFLASH_FIRST || ev_start > PFLASH_LAST) begin
                check_err = 1'b1;
            end
            if (ev_start[2:0] != 3'h0) begin
                check_err = 1'b1;
            end
            if (ev_end > ({2'b00, PFLASH_LAST} + 20'h00001)) begin
                check_err = 1'b1;
            end
        end else if (is_read_once) begin
            if (command_word_index != flash_pkg::RO_LAUNCH_INDEX ||
                cmd_word[1] > flash_pkg::RO_LAST_PHRASE) begin
                check_err = 1'b1;
            end
        end else begin
            check_err = 1'b1;
        end
    end

    // command word index register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            command_word_index <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == flash_pkg::OFF_CMD_INDEX && command_complete_flag) begin
            command_word_index <= reg_wdata_i[2:0];
        end
    end

    // command word storage: bus writes while idle, read-once results while busy
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < flash_pkg::CMD_WORDS; i++) begin
                cmd_word[i] <= 16'h0000;
            end
        end else if (reg_wr_i && reg_addr_i == flash_pkg::OFF_CMD_DATA && command_complete_flag) begin
            if (command_word_index < 3'(flash_pkg::CMD_WORDS)) begin
                cmd_word[command_word_index] <= reg_wdata_i;
            end
        end else if (word_ack && is_read_once) begin
            cmd_word[result_index] <= array_rdata_i;
        end
    end

    // status flags; a hardware set in the same cycle as a software clear wins
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            command_complete_flag     <= 1'b1;
            access_error_flag         <= 1'b0;
            protection_violation_flag <= 1'b0;
            array_op_status           <= 2'b00;
        end else begin
            if (status_wr && reg_wdata_i[flash_pkg::ACCESS_ERR_BIT]) begin
                access_error_flag <= 1'b0;
            end
            if (status_wr && reg_wdata_i[flash_pkg::PVIOL_BIT]) begin
                protection_violation_flag <= 1'b0;
            end
            if (launch) begin
                command_complete_flag <= 1'b0;
                array_op_status       <= 2'b00;
            end
            if (state == flash_pkg::S_CHECK && check_err) begin
                access_error_flag     <= 1'b1;
                command_complete_flag <= 1'b1;
            end
            if (word_ack && (array_ecc_single_i || array_ecc_double_i || blank_fail)) begin
                array_op_status[flash_pkg::OP_STATUS1_BIT] <= 1'b1;
            end
            if (word_ack && (array_ecc_double_i || blank_fail)) begin
                array_op_status[flash_pkg::OP_STATUS0_BIT] <= 1'b1;
            end
            if (state == flash_pkg::S_DONE) begin
                command_complete_flag <= 1'b1;
            end
        end
    end

    // sequencer: check, walk the array word by word, then complete
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state        <= flash_pkg::S_IDLE;
            array_req_o  <= 1'b0;
            array_ifr_o  <= 1'b0;
            array_addr_o <= 18'h00000;
            words_left   <= 18'h00000;
        end else begin
            case (state)
                flash_pkg::S_IDLE: begin
                    if (launch) begin
                        state <= flash_pkg::S_CHECK;
                    end
                end
                flash_pkg::S_CHECK: begin
                    if (check_err) begin
                        state <= flash_pkg::S_IDLE;
                    end else if (is_verify) begin
                        array_addr_o <= ev_start;
                        array_ifr_o  <= 1'b0;
                        words_left   <= {cmd_word[2], 2'b00};
                        array_req_o  <= cmd_word[2] != 16'h0000;
                        state        <= (cmd_word[2] != 16'h0000) ? flash_pkg::S_READ : flash_pkg::S_DONE;
                    end else begin
                        array_addr_o <= {12'h000, cmd_word[1][2:0], 3'b000};
                        array_ifr_o  <= 1'b1;
                        words_left   <= 18'(flash_pkg::PHRASE_WORDS);
                        array_req_o  <= 1'b1;
                        state        <= flash_pkg::S_READ;
                    end
                end
                flash_pkg::S_READ: begin
                    if (array_ack_i) begin
                        if (words_left == 18'h00001) begin
                            array_req_o <= 1'b0;
                            array_ifr_o <= 1'b0;
                            state       <= flash_pkg::S_DONE;
                        end else begin
                            array_addr_o <= array_addr_o + 18'h00002;
                        end
                        words_left <= words_left - 18'h00001;
                    end
                end
                flash_pkg::S_DONE: begin
                    state <= flash_pkg::S_IDLE;
                end
                default: begin
                    state <= flash_pkg::S_IDLE;
                end
            endcase
        end
    end

    // divider register writes go through; the host keeps them out of busy periods
    assign div_if.wr_en = reg_wr_i && reg_addr_i == flash_pkg::OFF_CLKDIV;
    assign div_if.wdata = reg_wdata_i[7:0];

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            timebase_tick_o <= 1'b0;
        end else begin
            timebase_tick_o <= div_if.tick;
        end
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 16'h0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                flash_pkg::OFF_CLKDIV:    reg_rdata_o <= {8'h00, div_if.value};
                flash_pkg::OFF_CMD_INDEX: reg_rdata_o <= {13'h0000, command_word_index};
                flash_pkg::OFF_CMD_DATA: begin
                    reg_rdata_o <= (command_word_index < 3'(flash_pkg::CMD_WORDS)) ?
                                   cmd_word[command_word_index] : 16'h0000;
                end
                flash_pkg::OFF_STATUS: begin
                    reg_rdata_o <= {8'h00, command_complete_flag, 1'b0, access_error_flag,
                                    protection_violation_flag, 2'b00, array_op_status};
                end
                default:                  reg_rdata_o <= 16'h0000;
            endcase
        end else begin
            reg_rdata_o <= 16'h0000;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_launch;
        launch && state == flash_pkg::S_IDLE;
    endsequence

    sequence s_check_fails;
        state == flash_pkg::S_CHECK && check_err;
    endsequence

    chk_launch_clears_flag: assert property (s_launch |=> !command_complete_flag
        && state == flash_pkg::S_CHECK)
        else $error("launch did not clear the complete flag");
    chk_done_sets_flag: assert property (state == flash_pkg::S_DONE |=> command_complete_flag
        && state == flash_pkg::S_IDLE)
        else $error("complete flag not set after the command");
    chk_index_error: assert property (state == flash_pkg::S_CHECK && is_verify
        && command_word_index != flash_pkg::EV_LAUNCH_INDEX |=> access_error_flag)
        else $error("wrong command index not flagged");
    chk_mode_error: assert property (state == flash_pkg::S_CHECK && is_verify
        && !mode_allows_verify_i |=> access_error_flag)
        else $error("unavailable mode not flagged");
    chk_align_error: assert property (state == flash_pkg::S_CHECK && is_verify
        && ev_start[2:0] != 3'h0 |=> access_error_flag && !array_req_o)
        else $error("misaligned start not flagged");
    chk_range_error: assert property (state == flash_pkg::S_CHECK && is_verify
        && (ev_start > PFLASH_LAST || ev_start < PFLASH_FIRST) |=> access_error_flag)
        else $error("invalid address not flagged");
    chk_error_no_start: assert property (s_check_fails |=> command_complete_flag
        && !array_req_o && state == flash_pkg::S_IDLE)
        else $error("array started despite access error");
    chk_blank_fail_both: assert property (blank_fail |=> array_op_status == 2'b11)
        else $error("blank check failure did not set both status bits");
    chk_single_bit1: assert property (word_ack && array_ecc_single_i |=> array_op_status[1])
        else $error("corrected read error not reported");
    chk_bit0_cause: assert property ($rose(array_op_status[0]) |->
        $past(array_ecc_double_i) || $past(blank_fail))
        else $error("status bit 0 set without uncorrectable error");
    chk_pviol_stable: assert property (state != flash_pkg::S_IDLE && !status_wr
        |=> $stable(protection_violation_flag))
        else $error("protection flag changed during command");
    chk_once_capture: assert property (word_ack && is_read_once |=>
        cmd_word[$past(result_index)] == $past(array_rdata_i))
        else $error("read-once word not returned");
endmodule
`default_nettype wire

// File: pkg/flash_pkg.sv
// constants shared by the flash command sequencer and its clock divider
// assumes a single bus clock domain and a 16-bit register port
`default_nettype none
package flash_pkg;

    localparam int          REG_ADDR_W       = 3;
    localparam int          REG_DATA_W       = 16;

    // register offsets on the plain register port
    localparam logic [2:0]  OFF_CLKDIV       = 3'h0;
    localparam logic [2:0]  OFF_CMD_INDEX    = 3'h1;
    localparam logic [2:0]  OFF_CMD_DATA     = 3'h2;
    localparam logic [2:0]  OFF_STATUS       = 3'h3;

    // nvm_status_register fields
    localparam int          COMPLETE_BIT     = 7;
    localparam int          ACCESS_ERR_BIT   = 5;
    localparam int          PVIOL_BIT        = 4;
    localparam int          OP_STATUS1_BIT   = 1;
    localparam int          OP_STATUS0_BIT   = 0;

    // flash_clock_divider fields
    localparam int          DIV_LOADED_BIT   = 7;
    localparam int          DIV_LOCK_BIT     = 6;
    localparam int          DIV_VALUE_W      = 6;
    localparam logic [7:0]  CLKDIV_RESET     = 8'h00;

    // command words
    localparam int          CMD_WORDS        = 6;
    localparam logic [7:0]  CMD_ERASE_VERIFY = 8'h03;
    localparam logic [7:0]  CMD_READ_ONCE    = 8'h04;
    localparam logic [2:0]  EV_LAUNCH_INDEX  = 3'h2;
    localparam logic [2:0]  RO_LAUNCH_INDEX  = 3'h1;
    localparam logic [2:0]  RO_FIRST_RESULT  = 3'h2;
    localparam logic [15:0] RO_LAST_PHRASE   = 16'h0007;

    // array geometry: a phrase is four 16-bit words
    localparam int          PHRASE_WORDS     = 4;
    localparam logic [15:0] ERASED_WORD      = 16'hffff;
    localparam logic [17:0] PFLASH_FIRST     = 18'h28000;
    localparam logic [17:0] PFLASH_LAST      = 18'h3ffff;

    typedef enum logic [1:0] {
        S_IDLE,
        S_CHECK,
        S_READ,
        S_DONE
    } seq_state_t;

endpackage
`default_nettype wire

// File: pkg/flash_clkdiv_if.sv
// carrier between the command sequencer and the flash clock divider
// assumes both ends run on the same bus clock
`timescale 1ns/10ps
`default_nettype none
interface flash_clkdiv_if;
    logic       wr_en;
    logic [7:0] wdata;
    logic [7:0] value;
    logic       tick;

    modport ctrl (output wr_en, output wdata, input value, input tick);
    modport div  (input wr_en, input wdata, output value, output tick);
endinterface
`default_nettype wire

// File: hw/flash_clkdiv.sv
// flash clock divider register and the timebase it derives
// assumes writes arrive one cycle long from the register port of the sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_clkdiv (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    flash_clkdiv_if.div     bus
);
    logic                                  divider_loaded;
    logic                                  divider_lock;
    logic [flash_pkg::DIV_VALUE_W-1:0]     divider_value;
    logic [flash_pkg::DIV_VALUE_W-1:0]     count;
    logic                                  tick;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            divider_loaded <= flash_pkg::CLKDIV_RESET[flash_pkg::DIV_LOADED_BIT];
            divider_lock   <= flash_pkg::CLKDIV_RESET[flash_pkg::DIV_LOCK_BIT];
            divider_value  <= flash_pkg::CLKDIV_RESET[flash_pkg::DIV_VALUE_W-1:0];
        end else if (bus.wr_en) begin
            divider_loaded <= 1'b1;
            if (bus.wdata[flash_pkg::DIV_LOCK_BIT]) begin
                divider_lock <= 1'b1;
            end
            if (!divider_lock) begin
                divider_value <= bus.wdata[flash_pkg::DIV_VALUE_W-1:0];
            end
        end
    end

    // divide by value plus one to give the timebase enable pulse
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count <= '0;
            tick  <= 1'b0;
        end else if (!divider_loaded || count == divider_value) begin
            count <= '0;
            tick  <= divider_loaded;
        end else begin
            count <= count + 1'b1;
            tick  <= 1'b0;
        end
    end

    assign bus.value = {divider_loaded, divider_lock, divider_value};
    assign bus.tick  = tick;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    chk_loaded_sticky: assert property (divider_loaded |=> divider_loaded)
        else $error("divider loaded flag dropped without reset");
    chk_loaded_on_write: assert property (bus.wr_en |=> divider_loaded)
        else $error("divider loaded flag not set by a write");
    chk_lock_holds_value: assert property (divider_lock |=> $stable(divider_value))
        else $error("locked divider value changed");
    chk_tick_spacing: assert property ($rose(tick) && divider_value == 6'h01 && !bus.wr_en
        |=> !tick ##1 tick)
        else $error("timebase tick spacing wrong");
endmodule
`default_nettype wire

// File: test/flash_array_model.sv
// program flash array stand-in: acks each word one cycle after it is requested
// assumes the sequencer's bus clock
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
    input  wire logic        clk_i,
    input  wire logic        req_i,
    input  wire logic        ifr_i,
    input  wire logic [17:0] addr_i,
    input  wire logic [17:0] bad_i,
    input  wire logic [17:0] sgl_i,
    input  wire logic [17:0] dbl_i,
    output logic             ack_o,
    output logic      [15:0] rdata_o,
    output logic             sgl_o,
    output logic             dbl_o
);
    always_ff @(posedge clk_i) begin
        ack_o <= req_i & ~ack_o;
        sgl_o <= req_i & ~ack_o & (addr_i == sgl_i);
        dbl_o <= req_i & ~ack_o & (addr_i == dbl_i);
        if (req_i & ~ack_o) begin
            rdata_o <= ifr_i ? addr_i[15:0] ^ 16'h5a5a : ((addr_i == bad_i) ? 16'h0000 : 16'hffff);
        end else begin
            rdata_o <= ~rdata_o;
        end
    end
endmodule
`default_nettype wire

// File: test/flash_cmd_verify_clkdiv_bench.sv
// bench for the flash command sequencer
// assumes the array stand-in answers every word
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_verify_clkdiv_bench;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, mode = 1, req, ifr, ack, sgl, dbl, tick;
    logic [2:0] addr = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata, adat, got;
    logic [17:0] aaddr, st, bad = 18'h00001, sg = 18'h00001, dg = 18'h00001;
    int fails = 0, check_count = 0, cyc = 0, ticks = 0, v, p;
    always #2 clk = ~clk;
    flash_cmd_seq i_dut (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .mode_allows_verify_i(mode), .array_req_o(req), .array_ifr_o(ifr),
        .array_addr_o(aaddr), .array_rdata_i(adat), .array_ack_i(ack), .array_ecc_single_i(sgl),
        .array_ecc_double_i(dbl), .timebase_tick_o(tick));
    flash_array_model i_array (.clk_i(clk), .req_i(req), .ifr_i(ifr), .addr_i(aaddr), .bad_i(bad),
        .sgl_i(sg), .dbl_i(dg), .ack_o(ack), .rdata_o(adat), .sgl_o(sgl), .dbl_o(dbl));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        ticks += (tick === 1'b1);
        if (cyc == 20000) begin
            fails++;
            stop_test;
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, input logic [15:0] e, input bit cmp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
        if (cmp) chk(got, e);
    endtask
    // loads three command words, sets the index, launches and polls for completion
    task automatic run(input logic [15:0] w0, w1, w2, input logic [2:0] ix, input logic [15:0] e);
        logic [15:0] w [3];
        w = '{w0, w1, w2};
        got = 16'h0000;
        for (int i = 0; i < 3; i++) begin
            wr_reg(3'h1, 16'(i));
            wr_reg(3'h2, w[i]);
        end
        wr_reg(3'h1, {13'h0000, ix});
        wr_reg(3'h3, 16'h0080);
        for (int i = 0; i < 100 && got[7] !== 1'b1; i++) rd_reg(3'h3, 16'h0000, 0);
        chk(got, e);
        wr_reg(3'h3, 16'h0020);
    endtask
    task automatic ev(input logic [17:0] a, input logic [15:0] n, input logic [2:0] ix, input logic [15:0] e);
        run(16'h0300 | {14'h0000, a[17:16]}, a[15:0], n, ix, e);
    endtask
    initial begin
        v = $urandom(32'h0c35);
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(3'h3, 16'h0080, 1);
        rd_reg(3'h0, 16'h0000, 1);
        rd_reg(3'h5, 16'h0000, 1);
        v = $urandom % 4;
        wr_reg(3'h0, 16'(v));
        rd_reg(3'h0, 16'h0080 | 16'(v), 1);
        wr_reg(3'h0, 16'h0040 | 16'(v));
        wr_reg(3'h0, 16'h003f);
        rd_reg(3'h0, 16'h00c0 | 16'(v), 1);
        p = ticks;
        repeat (8 * (v + 1)) @(posedge clk);
        #1 chk(16'(ticks - p), 16'h0008);
        st = flash_pkg::PFLASH_FIRST + 18'(($urandom % 64) * 8);
        ev(st, 16'h0003, 3'h2, 16'h0080);
        bad = st + 18'h0000a;
        ev(st, 16'h0003, 3'h2, 16'h0083);
        bad = 18'h00001;
        sg = st;
        ev(st, 16'h0003, 3'h2, 16'h0082);
        sg = 18'h00001;
        dg = st + 18'h00004;
        ev(st, 16'h0003, 3'h2, 16'h0083);
        dg = 18'h00001;
        ev(st | 18'h00004, 16'h0001, 3'h2, 16'h00a0);
        ev(18'h00000, 16'h0001, 3'h2, 16'h00a0);
        ev(flash_pkg::PFLASH_LAST - 18'h00007, 16'h0002, 3'h2, 16'h00a0);
        ev(st, 16'h0001, 3'h3, 16'h00a0);
        @(posedge clk) mode <= 1'b0;
        ev(st, 16'h0001, 3'h2, 16'h00a0);
        @(posedge clk) mode <= 1'b1;
        p = $urandom % 8;
        run(16'h0400, 16'(p), 16'h0000, 3'h1, 16'h0080);
        for (int n = 0; n < 4; n++) begin
            wr_reg(3'h1, 16'(n + 2));
            rd_reg(3'h2, 16'(p * 8 + n * 2) ^ 16'h5a5a, 1);
        end
        // second reset: lock and loaded flag clear, then a divide-by-two timebase
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(3'h0, 16'h0000, 1);
        rd_reg(3'h3, 16'h0080, 1);
        wr_reg(3'h0, 16'h0001);
        rd_reg(3'h0, 16'h0081, 1);
        p = ticks;
        repeat (16) @(posedge clk);
        #1 chk(16'(ticks - p), 16'h0008);
        stop_test;
    end
endmodule
`default_nettype wire
